// [sctp_cnt_if.sv]
`timescale 1ns/1ps
interface sctp_cnt_if;
	logic                       tick;
	logic                       updown;
	logic [sctp_pkg::CNT_W-1:0] limit_max;
	logic                       lim_ev;
	logic                       halt_ev;
	logic                       halt_clr;
	logic                       start_ev;
	logic                       stop_ev;
	logic [sctp_pkg::CNT_W-1:0] count;
	logic                       down;
	logic                       halted;
	logic                       stopped;

	modport ctl (
		output tick, updown, limit_max, lim_ev, halt_ev, halt_clr, start_ev, stop_ev,
		input  count, down, halted, stopped
	);
	modport cnt (
		input  tick, updown, limit_max, lim_ev, halt_ev, halt_clr, start_ev, stop_ev,
		output count, down, halted, stopped
	);
endinterface : sctp_cnt_if

// [sctp_counter.sv]
`timescale 1ns/1ps
module sctp_counter (
	input wire logic clk,
	input wire logic sys_rst,
	sctp_cnt_if.cnt  cif
);

	typedef struct packed {
		logic [sctp_pkg::CNT_W-1:0] count;
		sctp_pkg::sctp_cdir_t       dir;
		logic                       halted;
		logic                       stopped;
	} sctp_cnt_state_t;

	localparam sctp_cnt_state_t CNT_STATE_RST = '{
		count:   sctp_pkg::CNT_RST,
		dir:     sctp_pkg::CNT_UP,
		halted:  sctp_pkg::HALT_RST,
		stopped: sctp_pkg::STOP_RST
	};

	sctp_cnt_state_t s_q;
	sctp_cnt_state_t s_d;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		if (cif.halt_ev) begin
			s_d.halted = 1'b1;
		end else if (cif.halt_clr) begin
			s_d.halted = 1'b0;
		end
		if (cif.stop_ev) begin
			s_d.stopped = 1'b1;
		end else if (cif.start_ev) begin
			s_d.stopped = 1'b0;
		end
		if (!s_q.halted && !s_q.stopped && cif.tick) begin
			if (!cif.updown) begin
				s_d.dir = sctp_pkg::CNT_UP;
				if (cif.lim_ev || s_q.count >= cif.limit_max) begin
					s_d.count = sctp_pkg::CNT_RST;
				end else begin
					s_d.count = s_q.count + 1'b1;
				end
			end else begin
				case (s_q.dir)
					sctp_pkg::CNT_UP: begin
						if (cif.lim_ev || s_q.count >= cif.limit_max) begin
							s_d.dir = sctp_pkg::CNT_DOWN;
							if (s_q.count != sctp_pkg::CNT_RST) begin
								s_d.count = s_q.count - 1'b1;
							end
						end else begin
							s_d.count = s_q.count + 1'b1;
						end
					end
					sctp_pkg::CNT_DOWN: begin
						if (s_q.count == sctp_pkg::CNT_RST) begin
							s_d.dir = sctp_pkg::CNT_UP;
							if (cif.limit_max != sctp_pkg::CNT_RST) begin
								s_d.count = s_q.count + 1'b1;
							end
						end else begin
							s_d.count = s_q.count - 1'b1;
						end
					end
					default: begin
						s_d.dir = sctp_pkg::CNT_UP;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q <= CNT_STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign cif.count   = s_q.count;
	assign cif.down    = (s_q.dir == sctp_pkg::CNT_DOWN);
	assign cif.halted  = s_q.halted;
	assign cif.stopped = s_q.stopped;

endmodule : sctp_counter

// [sctp_pin_model.sv]
`timescale 1ns/1ps
module sctp_pin_model (
	input  wire logic       clk,
	input  wire logic       pulse,
	input  wire logic [1:0] sel,
	output logic      [3:0] pin_in,
	output logic      [3:0] tmr_match
);
	// Timer match lines keep moving so a stale pin mux shows up.
	initial begin
		pin_in = 4'h0;
		tmr_match = 4'h0;
	end
	always @(posedge clk) begin
		pin_in <= pulse ? (4'h1 << sel) : 4'h0;
		tmr_match <= tmr_match + 4'h5;
	end
endmodule : sctp_pin_model

// [sctp_pkg.sv]
package sctp_pkg;

	// ------------------------------------------------------------------
	// Widths and counts
	// ------------------------------------------------------------------
	localparam int CNT_W     = 32;
	localparam int HALF_W    = 16;
	localparam int ST_W      = 3;
	localparam int NUM_ST    = 8;
	localparam int NUM_IN    = 4;
	localparam int NUM_OUT   = 4;
	localparam int NUM_MATCH = 4;
	localparam int IDX_W     = 2;
	localparam int AUTO_LIM  = 0;

	// ------------------------------------------------------------------
	// Reset values and limits
	// ------------------------------------------------------------------
	localparam logic [CNT_W-1:0] MAX_UNIFIED = 32'hFFFFFFFF;
	localparam logic [CNT_W-1:0] MAX_SPLIT   = 32'h0000FFFF;
	localparam logic [CNT_W-1:0] CNT_RST     = 32'h00000000;
	localparam logic [ST_W-1:0]  STATE_RST   = 3'h0;
	localparam logic             HALT_RST    = 1'h1;
	localparam logic             STOP_RST    = 1'h0;

	// ------------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		COMB_OR    = 2'b00,
		COMB_MATCH = 2'b01,
		COMB_IO    = 2'b10,
		COMB_AND   = 2'b11
	} sctp_comb_t;

	typedef enum logic [1:0] {
		IO_LOW  = 2'b00,
		IO_RISE = 2'b01,
		IO_FALL = 2'b10,
		IO_HIGH = 2'b11
	} sctp_iocond_t;

	typedef enum logic [1:0] {
		DIR_BOTH = 2'b00,
		DIR_UP   = 2'b01,
		DIR_DOWN = 2'b10
	} sctp_dir_en_t;

	typedef enum logic {
		CNT_UP   = 1'b0,
		CNT_DOWN = 1'b1
	} sctp_cdir_t;

	typedef struct packed {
		logic [NUM_ST-1:0]  state_mask;
		logic               half;
		logic               match_hi;
		logic [IDX_W-1:0]   match_sel;
		logic               match_hold;
		logic               io_is_out;
		logic [IDX_W-1:0]   io_sel;
		sctp_iocond_t       io_cond;
		sctp_comb_t         comb;
		sctp_dir_en_t       dir_en;
		logic               st_load;
		logic [ST_W-1:0]    st_val;
		logic [NUM_OUT-1:0] out_set;
		logic [NUM_OUT-1:0] out_clr;
		logic               irq_en;
		logic               do_limit;
		logic               do_halt;
		logic               do_start;
		logic               do_stop;
	} sctp_evt_cfg_t;

endpackage : sctp_pkg

// [sctp_top.sv]
`timescale 1ns/1ps
module sctp_top #(
	parameter int NUM_EVT = 8
) (
	input  wire logic                                                  clk,
	input  wire logic                                                  sys_rst,
	input  wire logic                                                  split_mode,
	input  wire logic [1:0]                                            updown,
	input  wire logic                                                  auto_limit,
	input  wire logic                                                  clk_sel_en,
	input  wire logic [sctp_pkg::IDX_W-1:0]                            clk_sel_idx,
	input  wire logic [sctp_pkg::NUM_MATCH-1:0][sctp_pkg::CNT_W-1:0]   match_val,
	input  wire sctp_pkg::sctp_evt_cfg_t [NUM_EVT-1:0]                 evt_cfg,
	input  wire logic [1:0]                                            halt_clr,
	input  wire logic [sctp_pkg::NUM_IN-1:0]                           pin_in,
	input  wire logic [sctp_pkg::NUM_OUT-1:0]                          tmr_match,
	input  wire logic [sctp_pkg::NUM_OUT-1:0]                          pin_share,
	output logic      [sctp_pkg::NUM_OUT-1:0]                          pin_out,
	output logic      [NUM_EVT-1:0]                                    irq_req,
	output logic      [NUM_EVT-1:0]                                    event_fired,
	output logic      [1:0][sctp_pkg::ST_W-1:0]                        state,
	output logic      [1:0][sctp_pkg::CNT_W-1:0]                       count,
	output logic      [1:0]                                            halted
);

	if (NUM_EVT < 1 || NUM_EVT > 32) begin : g_bad_evt
		$error("NUM_EVT must lie between 1 and 32.");
	end

	typedef struct packed {
		logic [1:0][sctp_pkg::ST_W-1:0]      state;
		logic [1:0][sctp_pkg::NUM_MATCH-1:0] mheld;
		logic [sctp_pkg::NUM_IN-1:0]         in_prev;
		logic [sctp_pkg::NUM_OUT-1:0]        outs;
		logic [sctp_pkg::NUM_OUT-1:0]        out_prev;
		logic [sctp_pkg::NUM_OUT-1:0]        pins;
		logic [NUM_EVT-1:0]                  irq;
		logic [NUM_EVT-1:0]                  fired;
	} sctp_top_state_t;

	sctp_top_state_t s_q;
	sctp_top_state_t s_d;

	// ------------------------------------------------------------------
	// Condition decode shared by inputs and outputs
	// ------------------------------------------------------------------
	function automatic logic sctp_io_ok(
		input sctp_pkg::sctp_iocond_t cond,
		input logic                   now,
		input logic                   prev
	);
		case (cond)
			sctp_pkg::IO_LOW:  sctp_io_ok = !now;
			sctp_pkg::IO_RISE: sctp_io_ok = now && !prev;
			sctp_pkg::IO_FALL: sctp_io_ok = !now && prev;
			sctp_pkg::IO_HIGH: sctp_io_ok = now;
			default:           sctp_io_ok = 1'b0;
		endcase
	endfunction : sctp_io_ok

	// ------------------------------------------------------------------
	// Counters
	// ------------------------------------------------------------------
	sctp_cnt_if cif [2] ();

	logic                                     tick;
	logic [1:0][sctp_pkg::CNT_W-1:0]          cnt;
	logic [1:0]                               dn;
	logic [1:0][sctp_pkg::CNT_W-1:0]          lim_max;
	logic [1:0]                               lim_ev;
	logic [1:0]                               halt_ev;
	logic [1:0]                               start_ev;
	logic [1:0]                               stop_ev;
	logic [1:0]                               upd;

	for (genvar g = 0; g < 2; g++) begin : g_half
		sctp_counter u_counter (
			.clk     (clk),
			.sys_rst (sys_rst),
			.cif     (cif[g])
		);
		assign cif[g].tick      = tick;
		assign cif[g].updown    = upd[g];
		assign cif[g].limit_max = lim_max[g];
		assign cif[g].lim_ev    = lim_ev[g];
		assign cif[g].halt_ev   = halt_ev[g];
		assign cif[g].halt_clr  = halt_clr[g];
		assign cif[g].start_ev  = start_ev[g];
		assign cif[g].stop_ev   = stop_ev[g];
		assign cnt[g]           = cif[g].count;
		assign dn[g]            = cif[g].down;
		assign halted[g]        = cif[g].halted;
	end

	// The upper counter only counts up-down in split mode; unified mode forces updown[1] low so it counts up.
	assign upd = {updown[1] & split_mode, updown[0]};

	// ------------------------------------------------------------------
	// Clock selection and limits
	// ------------------------------------------------------------------
	always_comb begin
		tick = 1'b1;
		if (clk_sel_en) begin
			tick = pin_in[clk_sel_idx] && !s_q.in_prev[clk_sel_idx];
		end
	end

	always_comb begin
		if (!split_mode) begin
			lim_max[0] = auto_limit ? match_val[sctp_pkg::AUTO_LIM] : sctp_pkg::MAX_UNIFIED;
			lim_max[1] = sctp_pkg::MAX_SPLIT;
		end else begin
			lim_max[0] = sctp_pkg::MAX_SPLIT;
			lim_max[1] = sctp_pkg::MAX_SPLIT;
			if (auto_limit) begin
				lim_max[0] = {16'h0000, match_val[sctp_pkg::AUTO_LIM][15:0]};
				lim_max[1] = {16'h0000, match_val[sctp_pkg::AUTO_LIM][31:16]};
			end
		end
	end

	// ------------------------------------------------------------------
	// Match detection, per half
	// ------------------------------------------------------------------
	logic [1:0][sctp_pkg::NUM_MATCH-1:0] hit;

	always_comb begin
		for (int j = 0; j < sctp_pkg::NUM_MATCH; j++) begin
			if (split_mode) begin
				hit[0][j] = tick && (cnt[0][15:0] == match_val[j][15:0]);
				hit[1][j] = tick && (cnt[1][15:0] == match_val[j][31:16]);
			end else begin
				hit[0][j] = tick && (cnt[0] == match_val[j]);
				hit[1][j] = 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Events and their effects
	// ------------------------------------------------------------------
	logic [NUM_EVT-1:0]           ev;
	logic [NUM_EVT-1:0]           ev_half;
	logic [sctp_pkg::NUM_OUT-1:0] set_acc;
	logic [sctp_pkg::NUM_OUT-1:0] clr_acc;
	logic [1:0]                   any_ev;
	sctp_pkg::sctp_evt_cfg_t      c;
	logic                         h;
	logic                         mh;
	logic                         mt;
	logic                         iot;
	logic                         cmb;
	logic                         dir_ok;

	always_comb begin
		s_d      = s_q;
		ev       = '0;
		ev_half  = '0;
		set_acc  = '0;
		clr_acc  = '0;
		any_ev   = '0;
		lim_ev   = '0;
		halt_ev  = '0;
		start_ev = '0;
		stop_ev  = '0;
		c        = '0;
		h        = 1'b0;
		mh       = 1'b0;
		mt       = 1'b0;
		iot      = 1'b0;
		cmb      = 1'b0;
		dir_ok   = 1'b1;
		for (int e = 0; e < NUM_EVT; e++) begin
			c  = evt_cfg[e];
			h  = split_mode && c.half;
			mh = split_mode && c.match_hi;
			mt = hit[mh][c.match_sel];
			if (c.match_hold) begin
				mt = mt || s_q.mheld[mh][c.match_sel];
			end
			if (c.io_is_out) begin
				iot = sctp_io_ok(c.io_cond, s_q.outs[c.io_sel], s_q.out_prev[c.io_sel]);
			end else begin
				iot = sctp_io_ok(c.io_cond, pin_in[c.io_sel], s_q.in_prev[c.io_sel]);
			end
			case (c.comb)
				sctp_pkg::COMB_OR:    cmb = mt || iot;
				sctp_pkg::COMB_MATCH: cmb = mt;
				sctp_pkg::COMB_IO:    cmb = iot;
				sctp_pkg::COMB_AND:   cmb = mt && iot;
				default:              cmb = 1'b0;
			endcase
			case (c.dir_en)
				sctp_pkg::DIR_UP:   dir_ok = !upd[h] || !dn[h];
				sctp_pkg::DIR_DOWN: dir_ok = upd[h] && dn[h];
				default:            dir_ok = 1'b1;
			endcase
			ev[e]      = cmb && dir_ok && c.state_mask[s_q.state[h]];
			ev_half[e] = h;
			if (ev[e]) begin
				any_ev[h]   = 1'b1;
				set_acc     = set_acc | c.out_set;
				clr_acc     = clr_acc | c.out_clr;
				lim_ev[h]   = lim_ev[h] || c.do_limit;
				halt_ev[h]  = halt_ev[h] || c.do_halt;
				start_ev[h] = start_ev[h] || c.do_start;
				stop_ev[h]  = stop_ev[h] || c.do_stop;
				if (c.st_load) begin
					s_d.state[h] = c.st_val;
				end
			end
		end
		// Setting and clearing one output in the same cycle toggles it.
		for (int i = 0; i < sctp_pkg::NUM_OUT; i++) begin
			if (set_acc[i] && clr_acc[i]) begin
				s_d.outs[i] = !s_q.outs[i];
			end else if (set_acc[i]) begin
				s_d.outs[i] = 1'b1;
			end else if (clr_acc[i]) begin
				s_d.outs[i] = 1'b0;
			end
			s_d.pins[i] = pin_share[i] ? tmr_match[i] : s_d.outs[i];
		end
		// A fresh match in the clearing cycle stays held.
		for (int k = 0; k < 2; k++) begin
			if (any_ev[k]) begin
				s_d.mheld[k] = '0;
			end
			s_d.mheld[k] = s_d.mheld[k] | hit[k];
		end
		s_d.in_prev  = pin_in;
		s_d.out_prev = s_q.outs;
		s_d.fired    = ev;
		for (int e = 0; e < NUM_EVT; e++) begin
			s_d.irq[e] = ev[e] && evt_cfg[e].irq_en;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q       <= '0;
			s_q.state <= {sctp_pkg::STATE_RST, sctp_pkg::STATE_RST};
		end else begin
			s_q <= s_d;
		end
	end

	assign pin_out     = s_q.pins;
	assign irq_req     = s_q.irq;
	assign event_fired = s_q.fired;
	assign state       = s_q.state;
	assign count       = cnt;

endmodule : sctp_top

// [sctp_top_asserts.sv]
`timescale 1ns/1ps
module sctp_top_asserts #(
	parameter int NUM_EVT = 8
) (
	input wire logic                                clk,
	input wire logic                                sys_rst,
	input wire logic                                split_mode,
	input wire logic [1:0]                          updown,
	input wire logic                                auto_limit,
	input wire logic                                clk_sel_en,
	input wire logic [1:0]                          clk_sel_idx,
	input wire logic [3:0][31:0]                    match_val,
	input wire sctp_pkg::sctp_evt_cfg_t [NUM_EVT-1:0] evt_cfg,
	input wire logic [1:0]                          halt_clr,
	input wire logic [3:0]                          pin_in,
	input wire logic [3:0]                          tmr_match,
	input wire logic [3:0]                          pin_share,
	input wire logic [3:0]                          pin_out,
	input wire logic [NUM_EVT-1:0]                  irq_req,
	input wire logic [NUM_EVT-1:0]                  event_fired,
	input wire logic [1:0][2:0]                     state,
	input wire logic [1:0][31:0]                    count,
	input wire logic [1:0]                          halted
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// ------------------------------------------------------------------
	// Counter properties
	// ------------------------------------------------------------------
	// A stop event freezes the count with no trace at the ports, so stepping is
	// only checked while no event is configured to stop a counter.
	logic stop_used;
	always_comb begin
		stop_used = 1'b0;
		for (int e = 0; e < NUM_EVT; e++) begin
			stop_used = stop_used | evt_cfg[e].do_stop;
		end
	end
	sequence s_run;
		!halted[0] && !clk_sel_en && !updown[0] && !stop_used;
	endsequence
	sequence s_at_lim;
		auto_limit && !split_mode && count[0] == match_val[0];
	endsequence
	property p_rst;
		$past(sys_rst) |-> count == '0 && state == '0 && pin_out == 4'h0 && halted == 2'h3;
	endproperty
	property p_step;
		s_run |=> count[0] == $past(count[0]) + 1 || count[0] == '0 || event_fired != '0;
	endproperty
	property p_wrap;
		s_run ##0 s_at_lim |=> count[0] == '0 || event_fired != '0;
	endproperty
	property p_halt;
		halted[0] |=> count[0] == $past(count[0]) || event_fired != '0;
	endproperty
	property p_unhalt;
		$fell(halted[0]) |-> $past(halt_clr[0]);
	endproperty
	property p_clk_sel;
		clk_sel_en && !(pin_in[clk_sel_idx] && !$past(pin_in[clk_sel_idx]))
			|=> count[0] == $past(count[0]) || event_fired != '0;
	endproperty
	// ------------------------------------------------------------------
	// Event properties
	// ------------------------------------------------------------------
	property p_mask;
		event_fired[0] && $past(!split_mode) |-> $past(evt_cfg[0].state_mask[state[0]]);
	endproperty
	property p_irq;
		irq_req[0] |-> event_fired[0] && $past(evt_cfg[0].irq_en);
	endproperty
	property p_state;
		!$past(sys_rst) && state[0] != $past(state[0]) |-> event_fired != '0;
	endproperty
	property p_out;
		!$past(sys_rst) && !$past(pin_share[0]) && !$past(pin_share[0], 2)
			&& pin_out[0] != $past(pin_out[0]) |-> event_fired != '0;
	endproperty
	property p_share;
		!$past(sys_rst) |-> ((pin_out ^ $past(tmr_match)) & $past(pin_share)) == 4'h0;
	endproperty

	a_rst: assert property (p_rst) else $error("reset values wrong");
	a_step: assert property (p_step) else $error("count did not advance");
	a_wrap: assert property (p_wrap) else $error("no wrap at limit");
	a_halt: assert property (p_halt) else $error("halted counter moved");
	a_unhalt: assert property (p_unhalt) else $error("halt left without clear");
	a_clk_sel: assert property (p_clk_sel) else $error("count without input edge");
	a_mask: assert property (p_mask) else $error("event in masked state");
	a_irq: assert property (p_irq) else $error("irq without event");
	a_state: assert property (p_state) else $error("state moved without event");
	a_out: assert property (p_out) else $error("output moved without event");
	a_share: assert property (p_share) else $error("shared pin wrong");
endmodule : sctp_top_asserts

bind sctp_top sctp_top_asserts #(.NUM_EVT(NUM_EVT)) i_chk (.clk(clk), .sys_rst(sys_rst),
	.split_mode(split_mode), .updown(updown), .auto_limit(auto_limit),
	.clk_sel_en(clk_sel_en), .clk_sel_idx(clk_sel_idx), .match_val(match_val),
	.evt_cfg(evt_cfg), .halt_clr(halt_clr), .pin_in(pin_in), .tmr_match(tmr_match),
	.pin_share(pin_share), .pin_out(pin_out), .irq_req(irq_req),
	.event_fired(event_fired), .state(state), .count(count), .halted(halted));

// [state_configurable_timer_pwm_test.sv]
`timescale 1ns/1ps
module state_configurable_timer_pwm_test;
	logic                         clk, sys_rst, split_mode, auto_limit, clk_sel_en, pulse;
	logic [1:0]                   updown, clk_sel_idx, halt_clr, psel, halted;
	logic [3:0][31:0]             match_val;
	sctp_pkg::sctp_evt_cfg_t [7:0] evt_cfg;
	sctp_pkg::sctp_evt_cfg_t       cfg;
	logic [3:0]                   pin_in, tmr_match, pin_share, pin_out, tm;
	logic [7:0]                   irq_req, event_fired;
	logic [1:0][2:0]              state;
	logic [1:0][31:0]             count;
	int                           fails, n_tests;

	sctp_top i_dut (.clk(clk), .sys_rst(sys_rst), .split_mode(split_mode), .updown(updown),
		.auto_limit(auto_limit), .clk_sel_en(clk_sel_en), .clk_sel_idx(clk_sel_idx),
		.match_val(match_val), .evt_cfg(evt_cfg), .halt_clr(halt_clr), .pin_in(pin_in),
		.tmr_match(tmr_match), .pin_share(pin_share), .pin_out(pin_out), .irq_req(irq_req),
		.event_fired(event_fired), .state(state), .count(count), .halted(halted));
	sctp_pin_model i_pins (.clk(clk), .pulse(pulse), .sel(psel), .pin_in(pin_in),
		.tmr_match(tmr_match));

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task do_reset;
		if ($time > 0) @(posedge clk);
		sys_rst <= 1'h1;
		{split_mode, updown, auto_limit, clk_sel_en, clk_sel_idx} <= '0;
		{match_val, evt_cfg, halt_clr, pin_share, pulse, psel} <= '0;
		repeat (20) @(posedge clk);
		sys_rst <= 1'h0;
		tick(1);
	endtask : do_reset
	task clr_halt(input logic [1:0] h);
		@(posedge clk);
		halt_clr <= h;
		@(posedge clk);
		halt_clr <= 2'h0;
		#1;
	endtask : clr_halt
	task wait_fire(input int i);
		int k;
		k = 0;
		do begin
			tick(1);
			k++;
		end while (event_fired[i] !== 1'h1 && k < 60);
		chk("event_fired", 32'h1, event_fired[i]);
	endtask : wait_fire
	task final_report;
		if (fails == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : final_report
	function automatic sctp_pkg::sctp_evt_cfg_t ev(input logic [7:0] m, input logic h,
		input logic [1:0] s, input sctp_pkg::sctp_comb_t c, input sctp_pkg::sctp_dir_en_t d,
		input logic [2:0] sv, input logic [3:0] st, input logic [3:0] cl, input logic hl);
		sctp_pkg::sctp_evt_cfg_t e;
		e = '0;
		{e.state_mask, e.half, e.match_hi, e.match_sel, e.io_sel} = {m, h, h, s, s};
		e.io_cond = sctp_pkg::IO_RISE;
		e.comb = c;
		e.dir_en = d;
		{e.st_load, e.st_val, e.out_set, e.out_clr, e.irq_en, e.do_halt} = {1'h1, sv, st, cl, 1'h1, hl};
		return e;
	endfunction : ev

	// ------------------------------------------------------------------
	// Clock, watchdog and tests
	// ------------------------------------------------------------------
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		final_report;
	end
	initial begin
		fails = 0;
		n_tests = 0;
		do_reset;
		chk("count", 32'h0, count[0] | count[1]);
		chk("state", 32'h0, state);
		chk("pin_out", 32'h0, pin_out);
		chk("halted", 32'h3, halted);
		clr_halt(2'h1);
		chk("halted", 32'h2, halted);
		tick(10);
		chk("count0", 32'hA, count[0]);
		do_reset;
		@(posedge clk);
		auto_limit <= 1'h1;
		match_val[0] <= 32'h7;
		match_val[2] <= 32'h3;
		evt_cfg[0] <= ev(8'h01, 1'h0, 2'h2, sctp_pkg::COMB_MATCH, sctp_pkg::DIR_BOTH, 3'h1, 4'h1, 4'h0, 1'h0);
		evt_cfg[1] <= ev(8'h02, 1'h0, 2'h2, sctp_pkg::COMB_MATCH, sctp_pkg::DIR_BOTH, 3'h2, 4'h0, 4'h1, 1'h0);
		clr_halt(2'h1);
		wait_fire(0);
		chk("pin_out", 32'h1, pin_out);
		chk("state0", 32'h1, state[0]);
		chk("irq_req", 32'h1, irq_req);
		wait_fire(1);
		chk("pin_out", 32'h0, pin_out);
		tick(20);
		chk("state0", 32'h2, state[0]);
		do_reset;
		@(posedge clk);
		split_mode <= 1'h1;
		match_val[1] <= 32'h00090000;
		evt_cfg[2] <= ev(8'hFF, 1'h1, 2'h1, sctp_pkg::COMB_MATCH, sctp_pkg::DIR_BOTH, 3'h3, 4'h4, 4'h0, 1'h1);
		clr_halt(2'h2);
		tick(5);
		chk("count1", 32'h5, count[1]);
		chk("count0", 32'h0, count[0]);
		wait_fire(2);
		chk("state", 32'h18, state);
		chk("pin_out", 32'h4, pin_out);
		tick(5);
		chk("halted", 32'h3, halted);
		chk("count1", 32'hA, count[1]);
		do_reset;
		@(posedge clk);
		clk_sel_en <= 1'h1;
		clk_sel_idx <= 2'h2;
		psel <= 2'h2;
		evt_cfg[4] <= ev(8'hFF, 1'h0, 2'h2, sctp_pkg::COMB_IO, sctp_pkg::DIR_BOTH, 3'h0, 4'h2, 4'h0, 1'h0);
		clr_halt(2'h1);
		repeat (5) begin
			@(posedge clk);
			pulse <= 1'h1;
			@(posedge clk);
			pulse <= 1'h0;
			tick(2);
		end
		chk("count0", 32'h5, count[0]);
		chk("pin_out", 32'h2, pin_out);
		@(posedge clk);
		pin_share <= 4'hF;
		@(negedge clk);
		tm = tmr_match;
		tick(1);
		chk("pin_out", tm, pin_out);
		do_reset;
		@(posedge clk);
		updown <= 2'h1;
		auto_limit <= 1'h1;
		match_val[0] <= 32'h4;
		match_val[3] <= 32'h2;
		evt_cfg[5] <= ev(8'hFF, 1'h0, 2'h3, sctp_pkg::COMB_MATCH, sctp_pkg::DIR_DOWN, 3'h0, 4'h8, 4'h0, 1'h0);
		clr_halt(2'h1);
		tick(4);
		chk("count0", 32'h4, count[0]);
		chk("pin_out", 32'h0, pin_out);
		wait_fire(5);
		chk("count0", 32'h1, count[0]);
		chk("pin_out", 32'h8, pin_out);
		do_reset;
		@(posedge clk);
		psel <= 2'h1;
		match_val[1] <= 32'h3;
		cfg = ev(8'hFF, 1'h0, 2'h1, sctp_pkg::COMB_AND, sctp_pkg::DIR_UP, 3'h1, 4'h1, 4'h0, 1'h0);
		{cfg.match_hold, cfg.do_stop, cfg.irq_en} = 3'b110;
		evt_cfg[6] <= cfg;
		cfg = ev(8'h02, 1'h0, 2'h0, sctp_pkg::COMB_OR, sctp_pkg::DIR_BOTH, 3'h2, 4'h1, 4'h1, 1'h0);
		cfg.io_cond = sctp_pkg::IO_HIGH;
		{cfg.io_is_out, cfg.do_start} = 2'b11;
		evt_cfg[7] <= cfg;
		cfg = ev(8'h04, 1'h0, 2'h0, sctp_pkg::COMB_IO, sctp_pkg::DIR_BOTH, 3'h3, 4'h0, 4'h0, 1'h0);
		cfg.io_cond = sctp_pkg::IO_FALL;
		{cfg.io_is_out, cfg.do_limit} = 2'b11;
		evt_cfg[5] <= cfg;
		clr_halt(2'h1);
		tick(4);
		@(posedge clk);
		pulse <= 1'h1;
		@(posedge clk);
		pulse <= 1'h0;
		tick(1);
		chk("event_fired", 32'h40, event_fired);
		chk("irq_req", 32'h0, irq_req);
		chk("state", 32'h1, state);
		chk("pin_out", 32'h1, pin_out);
		tick(1);
		chk("event_fired", 32'h80, event_fired);
		chk("irq_req", 32'h80, irq_req);
		chk("count0", 32'h7, count[0]);
		chk("pin_out", 32'h0, pin_out);
		tick(1);
		chk("event_fired", 32'h20, event_fired);
		chk("count0", 32'h0, count[0]);
		tick(2);
		chk("count0", 32'h2, count[0]);
		chk("state", 32'h3, state);
		final_report;
	end
endmodule : state_configurable_timer_pwm_test
